// [lcc_pkg.sv]
// Constants, command encodings and carrier types of the loop code command control block.
package lcc_pkg;

	// ----------------------------------------------------------------------
	// Register offsets and fields
	// ----------------------------------------------------------------------
	localparam logic [7:0] OFF_MODE     = 8'h00;
	localparam logic [7:0] OFF_LOOPTYPE = 8'h04;
	localparam logic [7:0] OFF_LOOPUP   = 8'h08;
	localparam logic [7:0] OFF_LOOPDOWN = 8'h0C;
	localparam logic [7:0] OFF_CODE     = 8'h10;
	localparam logic [7:0] OFF_PGMUP    = 8'h14;
	localparam logic [7:0] OFF_PGMDOWN  = 8'h18;
	localparam logic [7:0] OFF_STATUS   = 8'h1C;

	localparam int ARG_BIT       = 31;
	localparam int ON_BIT        = 0;
	localparam int SEL_LSB       = 0;
	localparam int CODE_ADDR_LSB = 8;

	localparam logic [7:0] MODECMD_LOCAL    = 8'h00;
	localparam logic [7:0] MODECMD_SLASH    = 8'h01;
	localparam logic [7:0] MODECMD_REMOTE   = 8'h02;
	localparam logic [7:0] MODECMD_TERMINAL = 8'h03;
	localparam logic [7:0] MODECMD_PERIOD   = 8'h04;

	// ----------------------------------------------------------------------
	// Address ranges
	// ----------------------------------------------------------------------
	localparam logic [7:0] ADDR_MIN       = 8'h01;
	localparam logic [7:0] REP_ADDR_MAX   = 8'h14;
	localparam logic [7:0] OR_ADDR_MAX    = 8'h02;
	localparam logic [7:0] MS_ADDR_MAX    = 8'h1C;
	localparam logic [5:0] LETTER_COUNT   = 6'h0C;
	localparam logic [5:0] DIGIT_COUNT    = 6'h03;
	localparam logic [1:0] FORM_LETTER    = 2'h0;
	localparam logic [1:0] FORM_A_LETTER  = 2'h1;

	// ----------------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------------
	localparam longint CLK_KHZ       = 100000;
	localparam longint LOOPUP_HOLD_MS = 250;
	localparam longint ARM_STEP_MS    = 2000;
	localparam int unsigned LOOPUP_HOLD_CYCLES = 32'(LOOPUP_HOLD_MS * CLK_KHZ);
	localparam int unsigned ARM_STEP_CYCLES    = 32'(ARM_STEP_MS * CLK_KHZ);

	// ----------------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------------
	typedef enum logic [1:0] {MODE_LOCAL, MODE_REMOTE, MODE_TERMINAL} lcc_mode_type;
	typedef enum logic [1:0] {TX_IDLE, TX_ARM, TX_MAIN} lcc_state_type;
	typedef enum logic [4:0] {
		SEL_CSU, SEL_FACILITY_ONE_CODE, SEL_FACILITY_TWO_CODE, SEL_FACILITY_THREE_CODE, SEL_PGM, SEL_OFF_ARM_A, SEL_OFF_ARM_B, SEL_NIU_ARM,
		SEL_LINE_REP_A, SEL_OFF_REP, SEL_POWER_THROUGH_CODE, SEL_POWER_DOWN_CODE, SEL_POWER_LOOP_CODE, SEL_QUERY, SEL_TIMEOUT_DISABLE_CODE,
		SEL_LINE_REP_B, SEL_OFF_REP_B, SEL_SEQ, SEL_POWER_LOOP_QUERY_CODE, SEL_MS_SW, SEL_MS_RAMP,
		SEL_OFFICE_C, SEL_FIELD_C, SEL_LIMIT
	} lcc_sel_type;
	typedef enum logic [3:0] {
		FN_NONE, FN_LOOPUP, FN_LOOPDOWN, FN_ARM, FN_DISARM, FN_NIU_UP, FN_NIU_DOWN, FN_SINGLE,
		FN_POWERLOOP, FN_RELEASE, FN_SEQLOOP, FN_MS_CMD, FN_MS_RESET
	} lcc_func_type;
	typedef struct packed {
		logic         active;
		logic         outband;
		lcc_sel_type  sel;
		lcc_func_type func;
		logic [7:0]   addr;
		logic [15:0]  user_programmed_code;
	} lcc_tx_type;

endpackage

// [lcc_loop_code_control.sv]
// Loop code command interpreter: local mode, loop type, loop-up/down transmit and code selection.
//
// Summary of operation
// - The local command leaves remote or terminal mode and hands control to the panel.
// - In local mode every front-panel switch is accepted, whatever the display mode.
// - Local mode holds until remote, terminal, period or any other valid command.
// - Loop-type command sets in-band or out-of-band, or reports it without argument.
// - The loop type also picks which kind of received loop code is answered.
// - The loop type applies only on extended superframe line formats.
// - Loop-down keeps sending until the code is no longer detected or disabled.
// - Loop-up keeps sending until detected continuously 250 ms or disabled.
// - The selected pattern arms automatic line loopback and drives the panel loop switches.
// - Selections cover CSU, facility one to three and separately programmed user codes.
// - Office-side arming: arm then interface loop-up; disarm then interface loop-down.
// - Interface-side arming sends only arm or disarm, toward the central office.
// - Addressed line-repeater selections take address 1 to 20, others rejected.
// - Power-thru, power-down, query and timeout-disable send one code either way.
// - Power-loop: loop-up sends power-loop, loop-down sends the release code.
// - The second vendor's office-repeater selection takes address 1 or 2 only.
// - Sequential loopback: loop-up sends sequential code, loop-down the ordinary code.
// - Maintenance switch and ramp selections take line card address 1 to 28.
// - Maintenance selections: arm then command on loop-up, arm then reset on loop-down.
// - Third vendor selections take the lettered, digit and A-prefixed address set.
//
// Decided for this implementation: the address map and the strobed register port.
`timescale 1ns/1ps

module lcc_loop_code_control #(
	parameter int unsigned LOOPUP_HOLD_CYCLES = lcc_pkg::LOOPUP_HOLD_CYCLES,
	parameter int unsigned ARM_STEP_CYCLES    = lcc_pkg::ARM_STEP_CYCLES
) (
	input  wire logic               core_clk,          // System clock, 100 MHz.
	input  wire logic               resetn,            // Asynchronous reset, active low.
	input  wire logic [7:0]         regAddr,           // Register byte address.
	input  wire logic [31:0]        regWrData,         // Register write data.
	input  wire logic               regWr,             // Write strobe.
	input  wire logic               regRd,             // Read strobe.
	output logic [31:0]             regRdData,         // Read data, valid the cycle after the strobe.
	input  wire logic               lineIsEsf,         // Line format is ESF or fractional ESF.
	input  wire logic               rxSelDetect,       // Receiver sees the code being sent.
	input  wire logic               rxLoopUpSeen,      // Selected loop-up code received.
	input  wire logic               rxLoopDownSeen,    // Selected loop-down code received.
	input  wire logic               rxOutband,         // Received code came out-of-band.
	input  wire logic               panelLoopUp,       // Front-panel loop-up switch pulse.
	input  wire logic               panelLoopDown,     // Front-panel loop-down switch pulse.
	output logic                    panelSwitchEnable, // Front-panel switches accepted.
	output lcc_pkg::lcc_tx_type     txCode,            // Code the transmitter must send.
	output logic                    respondOutband,    // Answer out-of-band codes, not in-band.
	output logic                    autoLineLoopback   // Automatic line loopback engaged.
);

	// ----------------------------------------------------------------------
	// Address decode and command classification
	// ----------------------------------------------------------------------
	logic mapped;
	logic hasArg;
	logic rejected;
	logic validCmd;
	logic wrMode;
	logic wrType;
	logic wrUp;
	logic wrDown;
	logic wrCode;
	lcc_pkg::lcc_sel_type newSel;
	logic [7:0] newAddr;
	always_comb begin
		mapped = (regAddr[1:0] == 2'h0) && (regAddr <= lcc_pkg::OFF_STATUS);
		hasArg = regWrData[lcc_pkg::ARG_BIT];
		wrMode = regWr && (regAddr == lcc_pkg::OFF_MODE);
		wrType = regWr && (regAddr == lcc_pkg::OFF_LOOPTYPE) && hasArg;
		wrUp   = regWr && (regAddr == lcc_pkg::OFF_LOOPUP) && hasArg;
		wrDown = regWr && (regAddr == lcc_pkg::OFF_LOOPDOWN) && hasArg;
		wrCode = regWr && (regAddr == lcc_pkg::OFF_CODE) && hasArg;
		newSel = lcc_pkg::lcc_sel_type'(regWrData[lcc_pkg::SEL_LSB +: 5]);
		newAddr = regWrData[lcc_pkg::CODE_ADDR_LSB +: 8];
		rejected = wrCode && ((regWrData[lcc_pkg::SEL_LSB +: 5] >= 5'(lcc_pkg::SEL_LIMIT))
			|| !addrValid(newSel, newAddr));
		validCmd = ((regWr && mapped) || (regRd && mapped)) && !rejected;
	end

	// Address check per selection; selections without an address always pass.
	function automatic logic addrValid(input lcc_pkg::lcc_sel_type sel, input logic [7:0] addr);
		logic [5:0] idx;
		idx = addr[5:0];
		case (sel)
			lcc_pkg::SEL_LINE_REP_A, lcc_pkg::SEL_LINE_REP_B:
				return (addr >= lcc_pkg::ADDR_MIN) && (addr <= lcc_pkg::REP_ADDR_MAX);
			lcc_pkg::SEL_OFF_REP_B:
				return (addr >= lcc_pkg::ADDR_MIN) && (addr <= lcc_pkg::OR_ADDR_MAX);
			lcc_pkg::SEL_MS_SW, lcc_pkg::SEL_MS_RAMP:
				return (addr >= lcc_pkg::ADDR_MIN) && (addr <= lcc_pkg::MS_ADDR_MAX);
			lcc_pkg::SEL_OFFICE_C, lcc_pkg::SEL_FIELD_C:
				if (addr[7:6] == lcc_pkg::FORM_LETTER || addr[7:6] == lcc_pkg::FORM_A_LETTER) begin
					return idx < lcc_pkg::LETTER_COUNT;
				end else begin
					return idx < lcc_pkg::DIGIT_COUNT;
				end
			default:
				return 1'b1;
		endcase
	endfunction

	// Selections that send an arming code before their main code.
	function automatic logic twoStep(input lcc_pkg::lcc_sel_type sel);
		return (sel == lcc_pkg::SEL_OFF_ARM_A) || (sel == lcc_pkg::SEL_OFF_ARM_B)
			|| (sel == lcc_pkg::SEL_MS_SW) || (sel == lcc_pkg::SEL_MS_RAMP);
	endfunction

	// Code function for a selection, direction and step.
	function automatic lcc_pkg::lcc_func_type codeFor(input lcc_pkg::lcc_sel_type sel, input logic up,
		input logic second);
		case (sel)
			lcc_pkg::SEL_OFF_ARM_A, lcc_pkg::SEL_OFF_ARM_B:
				if (second) begin
					return up ? lcc_pkg::FN_NIU_UP : lcc_pkg::FN_NIU_DOWN;
				end else begin
					return up ? lcc_pkg::FN_ARM : lcc_pkg::FN_DISARM;
				end
			lcc_pkg::SEL_NIU_ARM:
				return up ? lcc_pkg::FN_ARM : lcc_pkg::FN_DISARM;
			lcc_pkg::SEL_MS_SW, lcc_pkg::SEL_MS_RAMP:
				if (second) begin
					return up ? lcc_pkg::FN_MS_CMD : lcc_pkg::FN_MS_RESET;
				end else begin
					return lcc_pkg::FN_ARM;
				end
			lcc_pkg::SEL_POWER_THROUGH_CODE, lcc_pkg::SEL_POWER_DOWN_CODE, lcc_pkg::SEL_QUERY, lcc_pkg::SEL_POWER_LOOP_QUERY_CODE,
			lcc_pkg::SEL_TIMEOUT_DISABLE_CODE:
				return lcc_pkg::FN_SINGLE;
			lcc_pkg::SEL_POWER_LOOP_CODE:
				return up ? lcc_pkg::FN_POWERLOOP : lcc_pkg::FN_RELEASE;
			lcc_pkg::SEL_SEQ:
				return up ? lcc_pkg::FN_SEQLOOP : lcc_pkg::FN_LOOPDOWN;
			default:
				return up ? lcc_pkg::FN_LOOPUP : lcc_pkg::FN_LOOPDOWN;
		endcase
	endfunction

	// ----------------------------------------------------------------------
	// Control mode
	// ----------------------------------------------------------------------
	lcc_pkg::lcc_mode_type mode_reg;
	lcc_pkg::lcc_mode_type lastRemote_reg;
	logic localMode;
	logic wantLocal;
	assign localMode = (mode_reg == lcc_pkg::MODE_LOCAL);
	assign wantLocal = wrMode && (regWrData[7:0] == lcc_pkg::MODECMD_LOCAL
		|| regWrData[7:0] == lcc_pkg::MODECMD_SLASH);
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			mode_reg       <= lcc_pkg::MODE_LOCAL;
			lastRemote_reg <= lcc_pkg::MODE_REMOTE;
		end else if (wantLocal) begin
			if (!localMode) begin
				lastRemote_reg <= mode_reg;
			end
			mode_reg <= lcc_pkg::MODE_LOCAL;
		end else if (wrMode && regWrData[7:0] == lcc_pkg::MODECMD_REMOTE) begin
			mode_reg <= lcc_pkg::MODE_REMOTE;
		end else if (wrMode && regWrData[7:0] == lcc_pkg::MODECMD_TERMINAL) begin
			mode_reg <= lcc_pkg::MODE_TERMINAL;
		end else if (localMode && validCmd) begin
			// A period or any other valid command resumes the last remote-side mode.
			mode_reg <= lastRemote_reg;
		end
	end
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			panelSwitchEnable <= 1'b1;
		end else begin
			panelSwitchEnable <= localMode;
		end
	end

	// ----------------------------------------------------------------------
	// Settings
	// ----------------------------------------------------------------------
	logic outband_reg;
	lcc_pkg::lcc_sel_type sel_reg;
	logic [7:0] addr_reg;
	logic [15:0] pgmUp_reg;
	logic [15:0] pgmDown_reg;
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			outband_reg <= 1'b0;
		end else if (wrType) begin
			outband_reg <= regWrData[lcc_pkg::ON_BIT];
		end
	end
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			sel_reg  <= lcc_pkg::SEL_CSU;
			addr_reg <= 8'h01;
		end else if (wrCode && !rejected) begin
			sel_reg  <= newSel;
			addr_reg <= newAddr;
		end
	end
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			pgmUp_reg   <= 16'h0000;
			pgmDown_reg <= 16'h0000;
		end else begin
			if (regWr && regAddr == lcc_pkg::OFF_PGMUP && hasArg) begin
				pgmUp_reg <= regWrData[15:0];
			end
			if (regWr && regAddr == lcc_pkg::OFF_PGMDOWN && hasArg) begin
				pgmDown_reg <= regWrData[15:0];
			end
		end
	end
	// The type is only meaningful on ESF lines; elsewhere everything is in-band.
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			respondOutband <= 1'b0;
		end else begin
			respondOutband <= outband_reg && lineIsEsf;
		end
	end

	// ----------------------------------------------------------------------
	// Loop-up and loop-down transmission
	// ----------------------------------------------------------------------
	lcc_pkg::lcc_state_type state_reg;
	logic dirUp_reg;
	logic seen_reg;
	logic [31:0] count_reg;
	logic startUp;
	logic startDown;
	logic stopUp;
	logic stopDown;
	always_comb begin
		startUp   = (wrUp && regWrData[lcc_pkg::ON_BIT]) || (localMode && panelLoopUp);
		startDown = (wrDown && regWrData[lcc_pkg::ON_BIT]) || (localMode && panelLoopDown);
		stopUp    = wrUp && !regWrData[lcc_pkg::ON_BIT];
		stopDown  = wrDown && !regWrData[lcc_pkg::ON_BIT];
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			state_reg <= lcc_pkg::TX_IDLE;
			dirUp_reg <= 1'b0;
			seen_reg  <= 1'b0;
			count_reg <= 32'h00000000;
		end else if (startUp || startDown) begin
			// Starting one direction replaces any transfer already under way.
			state_reg <= twoStep(sel_reg) ? lcc_pkg::TX_ARM : lcc_pkg::TX_MAIN;
			dirUp_reg <= startUp;
			seen_reg  <= 1'b0;
			count_reg <= 32'h00000000;
		end else if ((stopUp && dirUp_reg) || (stopDown && !dirUp_reg)) begin
			state_reg <= lcc_pkg::TX_IDLE;
		end else begin
			unique case (state_reg)
				lcc_pkg::TX_IDLE: begin
					count_reg <= 32'h00000000;
				end
				lcc_pkg::TX_ARM: begin
					if (count_reg >= ARM_STEP_CYCLES - 1) begin
						state_reg <= lcc_pkg::TX_MAIN;
						count_reg <= 32'h00000000;
					end else begin
						count_reg <= count_reg + 32'h00000001;
					end
				end
				lcc_pkg::TX_MAIN: begin
					if (dirUp_reg) begin
						if (!rxSelDetect) begin
							count_reg <= 32'h00000000;
						end else if (count_reg >= LOOPUP_HOLD_CYCLES - 1) begin
							state_reg <= lcc_pkg::TX_IDLE;
						end else begin
							count_reg <= count_reg + 32'h00000001;
						end
					end else if (rxSelDetect) begin
						seen_reg <= 1'b1;
					end else if (seen_reg) begin
						state_reg <= lcc_pkg::TX_IDLE;
					end
				end
			endcase
		end
	end
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			txCode <= '{active: 1'b0, outband: 1'b0, sel: lcc_pkg::SEL_CSU, func: lcc_pkg::FN_NONE,
				addr: 8'h00, user_programmed_code: 16'h0000};
		end else begin
			txCode.active  <= (state_reg != lcc_pkg::TX_IDLE);
			txCode.outband <= outband_reg && lineIsEsf;
			txCode.sel     <= sel_reg;
			txCode.func    <= (state_reg == lcc_pkg::TX_IDLE) ? lcc_pkg::FN_NONE
				: codeFor(sel_reg, dirUp_reg, state_reg == lcc_pkg::TX_MAIN);
			txCode.addr    <= addr_reg;
			txCode.user_programmed_code     <= dirUp_reg ? pgmUp_reg : pgmDown_reg;
		end
	end

	// ----------------------------------------------------------------------
	// Automatic line loopback and status
	// ----------------------------------------------------------------------
	logic kindMatch;
	logic error_reg;

	assign kindMatch = (rxOutband == (outband_reg && lineIsEsf));
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			autoLineLoopback <= 1'b0;
		end else if (kindMatch && rxLoopUpSeen) begin
			autoLineLoopback <= 1'b1;
		end else if (kindMatch && rxLoopDownSeen) begin
			autoLineLoopback <= 1'b0;
		end
	end
	// A rejection in the same cycle as the status read survives the clear.
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			error_reg <= 1'b0;
		end else if (rejected) begin
			error_reg <= 1'b1;
		end else if (regRd && regAddr == lcc_pkg::OFF_STATUS) begin
			error_reg <= 1'b0;
		end
	end

	// ----------------------------------------------------------------------
	// Read port
	// ----------------------------------------------------------------------
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			regRdData <= 32'h00000000;
		end else if (regRd) begin
			case (regAddr)
				lcc_pkg::OFF_MODE:     regRdData <= {30'h00000000, mode_reg};
				lcc_pkg::OFF_LOOPTYPE: regRdData <= {31'h00000000, outband_reg};
				lcc_pkg::OFF_LOOPUP:   regRdData <= {31'h00000000,
					(state_reg != lcc_pkg::TX_IDLE) && dirUp_reg};
				lcc_pkg::OFF_LOOPDOWN: regRdData <= {31'h00000000,
					(state_reg != lcc_pkg::TX_IDLE) && !dirUp_reg};
				lcc_pkg::OFF_CODE:     regRdData <= {16'h0000, addr_reg, 3'h0, sel_reg};
				lcc_pkg::OFF_PGMUP:    regRdData <= {16'h0000, pgmUp_reg};
				lcc_pkg::OFF_PGMDOWN:  regRdData <= {16'h0000, pgmDown_reg};
				lcc_pkg::OFF_STATUS:   regRdData <= {26'h0000000, state_reg, autoLineLoopback,
					respondOutband, localMode, error_reg};
				default:               regRdData <= 32'h00000000;
			endcase
		end else begin
			regRdData <= 32'h00000000;
		end
	end

	// ----------------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------------
	sequence localReq;
		regWr && regAddr == lcc_pkg::OFF_MODE
			&& (regWrData[7:0] == lcc_pkg::MODECMD_LOCAL || regWrData[7:0] == lcc_pkg::MODECMD_SLASH);
	endsequence
	sequence outbandReq;
		regWr && regAddr == lcc_pkg::OFF_LOOPTYPE && regWrData[lcc_pkg::ARG_BIT]
			&& regWrData[lcc_pkg::ON_BIT] && lineIsEsf;
	endsequence
	a_local_entry: assert property (@(posedge core_clk) disable iff (!resetn)
		localReq |=> localMode ##1 panelSwitchEnable)
		else $error("local command did not enable the front panel");
	a_local_hold: assert property (@(posedge core_clk) disable iff (!resetn)
		localMode && !regWr && !regRd |=> localMode)
		else $error("local mode left without a command");
	a_local_exit: assert property (@(posedge core_clk) disable iff (!resetn)
		localMode && regRd && mapped && !regWr |=> !localMode ##1 !panelSwitchEnable)
		else $error("valid command did not leave local mode");
	a_type_gate: assert property (@(posedge core_clk) disable iff (!resetn)
		!lineIsEsf |=> !respondOutband && !txCode.outband)
		else $error("out-of-band used on a non-ESF line");
	a_type_follow: assert property (@(posedge core_clk) disable iff (!resetn)
		outbandReq ##1 (lineIsEsf && !(regWr && regAddr == lcc_pkg::OFF_LOOPTYPE)) |=> respondOutband)
		else $error("out-of-band selection not applied");
	a_down_stop: assert property (@(posedge core_clk) disable iff (!resetn)
		state_reg == lcc_pkg::TX_MAIN && !dirUp_reg && seen_reg && !rxSelDetect && !startUp && !startDown
			|=> state_reg == lcc_pkg::TX_IDLE ##1 !txCode.active)
		else $error("loop-down kept sending after the code vanished");
	a_up_hold: assert property (@(posedge core_clk) disable iff (!resetn)
		state_reg == lcc_pkg::TX_MAIN && dirUp_reg && rxSelDetect && !startUp && !startDown && !stopUp
			&& count_reg < LOOPUP_HOLD_CYCLES - 1 |=> state_reg == lcc_pkg::TX_MAIN)
		else $error("loop-up stopped before the hold time");
	a_up_disable: assert property (@(posedge core_clk) disable iff (!resetn)
		stopUp && dirUp_reg && !startDown |=> state_reg == lcc_pkg::TX_IDLE ##1 !txCode.active)
		else $error("loop-up disable ignored");
	a_addr_reject: assert property (@(posedge core_clk) disable iff (!resetn)
		regWr && regAddr == lcc_pkg::OFF_CODE && regWrData[lcc_pkg::ARG_BIT]
			&& regWrData[4:0] == 5'(lcc_pkg::SEL_LINE_REP_A) && regWrData[15:8] > lcc_pkg::REP_ADDR_MAX
			|=> $stable(sel_reg) && $stable(addr_reg) && error_reg)
		else $error("out-of-range repeater address accepted");

endmodule

// [lcc_span_model.sv]
// Far-end span model that returns the transmitted loop code after a line delay.
`timescale 1ns/1ps
module lcc_span_model (
	input  wire logic                core_clk,   // System clock.
	input  wire lcc_pkg::lcc_tx_type txCode,     // Code being sent.
	input  wire logic                mute,       // Span stops returning the code.
	output logic                     rxSelDetect // Code seen back.
);
	logic [2:0] delay_reg;
	// A looped span takes a few cycles to return the code, so detect never follows in the same cycle.
	always_ff @(posedge core_clk) begin
		delay_reg <= {delay_reg[1:0], txCode.active & ~mute};
	end
	assign rxSelDetect = delay_reg[2];
endmodule

// [lcc_loop_code_control_tb_top.sv]
// Self-checking testbench of the loop code command control block.
`timescale 1ns/1ps
module lcc_loop_code_control_tb_top;
	logic                core_clk = 0, resetn = 0, regWr = 0, regRd = 0, lineIsEsf = 1, mute = 0;
	logic                rxUp = 0, rxDown = 0, rxOutband = 0, panelUp = 0, panelDown = 0;
	logic [7:0]          regAddr = 8'h00;
	logic [31:0]         regWrData = 32'h0, regRdData, expCode;
	logic                pse, respOut, autoLlb, rxSelDetect;
	lcc_pkg::lcc_tx_type txCode;
	int                  nErrors = 0, numChecks = 0, cycles = 0;
	always #5 core_clk = ~core_clk;
	lcc_loop_code_control #(.LOOPUP_HOLD_CYCLES(20), .ARM_STEP_CYCLES(5)) uut (
		.core_clk(core_clk), .resetn(resetn), .regAddr(regAddr), .regWrData(regWrData),
		.regWr(regWr), .regRd(regRd), .regRdData(regRdData), .lineIsEsf(lineIsEsf),
		.rxSelDetect(rxSelDetect), .rxLoopUpSeen(rxUp), .rxLoopDownSeen(rxDown),
		.rxOutband(rxOutband), .panelLoopUp(panelUp), .panelLoopDown(panelDown),
		.panelSwitchEnable(pse), .txCode(txCode), .respondOutband(respOut), .autoLineLoopback(autoLlb));
	lcc_span_model span (.core_clk(core_clk), .txCode(txCode), .mute(mute), .rxSelDetect(rxSelDetect));
	// ----------------------------------------------------------------------
	// Bus and compare tasks
	// ----------------------------------------------------------------------
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		numChecks++;
		if (got !== exp) begin
			nErrors++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		regAddr <= a;
		regWrData <= d;
		regWr <= 1'b1;
		@(posedge core_clk);
		regWr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge core_clk);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge core_clk);
		regRd <= 1'b0;
		#1 chk(regRdData, e);
	endtask
	task automatic seen(input logic ob, input logic up);
		@(posedge core_clk);
		rxOutband <= ob;
		rxUp <= up;
		rxDown <= ~up;
		@(posedge core_clk);
		rxUp <= 1'b0;
		rxDown <= 1'b0;
		tick(1);
	endtask
	task automatic code(input lcc_pkg::lcc_sel_type s, input logic [7:0] a, input logic ok);
		wr(lcc_pkg::OFF_CODE, {16'h8000, a, 3'h0, s});
		if (ok) expCode = {16'h0, a, 3'h0, s};
		rd(lcc_pkg::OFF_CODE, expCode);
	endtask
	task automatic go(input lcc_pkg::lcc_sel_type s, input logic up, input lcc_pkg::lcc_func_type f);
		code(s, 8'h01, 1'b1);
		wr(up ? lcc_pkg::OFF_LOOPUP : lcc_pkg::OFF_LOOPDOWN, 32'h80000001);
		tick(1);
		chk(32'(txCode.func), 32'(f));
		chk(32'(txCode.sel), 32'(s));
		wr(up ? lcc_pkg::OFF_LOOPUP : lcc_pkg::OFF_LOOPDOWN, 32'h80000000);
		tick(1);
		chk(txCode.active, 1'b0);
	endtask
	task automatic tally_and_finish;
		$display("checks=%0d errors=%0d", numChecks, nErrors);
		if (nErrors == 0 && numChecks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	// ----------------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------------
	task automatic t_local;
		tick(2);
		chk(pse, 1'b1);
		@(posedge core_clk) panelUp <= 1'b1;
		@(posedge core_clk) panelUp <= 1'b0;
		tick(1);
		chk(32'(txCode.func), 32'(lcc_pkg::FN_LOOPUP));
		tick(40);
		chk(txCode.active, 1'b0);
		@(posedge core_clk) panelDown <= 1'b1;
		@(posedge core_clk) panelDown <= 1'b0;
		tick(1);
		chk(32'(txCode.func), 32'(lcc_pkg::FN_LOOPDOWN));
		tick(6);
		@(posedge core_clk) mute <= 1'b1;
		tick(8);
		chk(txCode.active, 1'b0);
		@(posedge core_clk) mute <= 1'b0;
	endtask
	task automatic t_mode;
		wr(lcc_pkg::OFF_MODE, 32'(lcc_pkg::MODECMD_REMOTE));
		rd(lcc_pkg::OFF_MODE, 32'h1);
		chk(pse, 1'b0);
		wr(lcc_pkg::OFF_MODE, 32'(lcc_pkg::MODECMD_SLASH));
		tick(2);
		chk(pse, 1'b1);
		wr(lcc_pkg::OFF_MODE, 32'(lcc_pkg::MODECMD_PERIOD));
		rd(lcc_pkg::OFF_MODE, 32'h1);
		wr(lcc_pkg::OFF_MODE, 32'(lcc_pkg::MODECMD_LOCAL));
		tick(2);
		chk(pse, 1'b1);
		rd(lcc_pkg::OFF_MODE, 32'h0);
		rd(lcc_pkg::OFF_MODE, 32'h1);
	endtask
	task automatic t_type;
		wr(lcc_pkg::OFF_LOOPTYPE, 32'h80000001);
		tick(2);
		chk(respOut, 1'b1);
		chk(txCode.outband, 1'b1);
		chk(pse, 1'b0);
		wr(lcc_pkg::OFF_LOOPTYPE, 32'h00000000);
		rd(lcc_pkg::OFF_LOOPTYPE, 32'h1);
		@(posedge core_clk) lineIsEsf <= 1'b0;
		tick(2);
		chk(respOut, 1'b0);
		chk(txCode.outband, 1'b0);
		@(posedge core_clk) lineIsEsf <= 1'b1;
		tick(2);
		seen(1'b0, 1'b1);
		chk(autoLlb, 1'b0);
		seen(1'b1, 1'b1);
		chk(autoLlb, 1'b1);
		seen(1'b0, 1'b0);
		chk(autoLlb, 1'b1);
		seen(1'b1, 1'b0);
		chk(autoLlb, 1'b0);
	endtask
	task automatic t_xfer;
		wr(lcc_pkg::OFF_LOOPDOWN, 32'h80000001);
		tick(10);
		wr(lcc_pkg::OFF_LOOPDOWN, 32'h00000000);
		rd(lcc_pkg::OFF_LOOPDOWN, 32'h1);
		@(posedge core_clk) mute <= 1'b1;
		tick(8);
		rd(lcc_pkg::OFF_LOOPDOWN, 32'h0);
		@(posedge core_clk) mute <= 1'b0;
		wr(lcc_pkg::OFF_LOOPUP, 32'h80000001);
		tick(12);
		rd(lcc_pkg::OFF_LOOPUP, 32'h1);
		tick(20);
		rd(lcc_pkg::OFF_LOOPUP, 32'h0);
	endtask
	task automatic t_addr;
		code(lcc_pkg::SEL_FACILITY_THREE_CODE, 8'h01, 1'b1);
		code(lcc_pkg::SEL_LINE_REP_A, 8'h00, 1'b0);
		code(lcc_pkg::SEL_LINE_REP_A, 8'h14, 1'b1);
		code(lcc_pkg::SEL_LINE_REP_B, 8'h15, 1'b0);
		code(lcc_pkg::SEL_OFF_REP_B, 8'h02, 1'b1);
		code(lcc_pkg::SEL_OFF_REP_B, 8'h03, 1'b0);
		code(lcc_pkg::SEL_MS_SW, 8'h1C, 1'b1);
		code(lcc_pkg::SEL_MS_RAMP, 8'h1D, 1'b0);
		code(lcc_pkg::SEL_OFFICE_C, 8'h4B, 1'b1);
		code(lcc_pkg::SEL_FIELD_C, 8'h0C, 1'b0);
		code(lcc_pkg::SEL_FIELD_C, 8'hC3, 1'b0);
		rd(lcc_pkg::OFF_STATUS, 32'h5);
		rd(lcc_pkg::OFF_STATUS, 32'h4);
	endtask
	task automatic t_func;
		go(lcc_pkg::SEL_POWER_THROUGH_CODE, 1'b0, lcc_pkg::FN_SINGLE);
		go(lcc_pkg::SEL_QUERY, 1'b1, lcc_pkg::FN_SINGLE);
		go(lcc_pkg::SEL_POWER_LOOP_CODE, 1'b1, lcc_pkg::FN_POWERLOOP);
		go(lcc_pkg::SEL_POWER_LOOP_CODE, 1'b0, lcc_pkg::FN_RELEASE);
		go(lcc_pkg::SEL_SEQ, 1'b1, lcc_pkg::FN_SEQLOOP);
		go(lcc_pkg::SEL_SEQ, 1'b0, lcc_pkg::FN_LOOPDOWN);
		go(lcc_pkg::SEL_NIU_ARM, 1'b1, lcc_pkg::FN_ARM);
		go(lcc_pkg::SEL_NIU_ARM, 1'b0, lcc_pkg::FN_DISARM);
		go(lcc_pkg::SEL_OFF_ARM_A, 1'b0, lcc_pkg::FN_DISARM);
		go(lcc_pkg::SEL_MS_SW, 1'b1, lcc_pkg::FN_ARM);
		wr(lcc_pkg::OFF_PGMDOWN, 32'h80005A5A);
		wr(lcc_pkg::OFF_PGMUP, 32'h0000A5A5);
		rd(lcc_pkg::OFF_PGMUP, 32'h0);
		go(lcc_pkg::SEL_PGM, 1'b0, lcc_pkg::FN_LOOPDOWN);
		chk(txCode.user_programmed_code, 32'h5A5A);
	endtask
	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 5000) begin
			nErrors++;
			tally_and_finish();
		end
	end
	initial begin
		repeat (6) @(posedge core_clk);
		resetn <= 1'b1;
		t_local();
		t_mode();
		t_type();
		t_xfer();
		t_addr();
		t_func();
		tally_and_finish();
	end
endmodule
